/* lmr_consts.svh */
// Purpose: Named constants for the file-operate and return execution block.
// Assumes: Byte offsets on a 32-bit APB, one register per aligned word.
// Notes: Opcode patterns match fields of the 14-bit instruction word.
`ifndef LMR_CONSTS_SVH
`define LMR_CONSTS_SVH

// Widths of the datapath, file space, program counter, instruction, stack pointer and cycle counter.
`define LMR_DW        8
`define LMR_FAW       7
`define LMR_PCW       13
`define LMR_IW        14
`define LMR_SPW       3
`define LMR_CYW       16

// Register byte offsets.
`define LMR_OFF_INSTR 8'h00
`define LMR_OFF_ACCUM 8'h04
`define LMR_OFF_STAT  8'h08
`define LMR_OFF_PC    8'h0c
`define LMR_OFF_STACK 8'h10
`define LMR_OFF_FADDR 8'h14
`define LMR_OFF_FDATA 8'h18
`define LMR_OFF_CYC   8'h1c

// Status register bit positions.
`define LMR_ST_C      0
`define LMR_ST_Z      2
`define LMR_ST_GLOBEN 7

// Instruction fields.
`define LMR_F_MSB     6
`define LMR_D_BIT     7
`define LMR_K_MSB     7
`define LMR_OP_MSB    13
`define LMR_OP_LSB    8
`define LMR_RL_LSB    10

// Opcode patterns (bits 13:8; STORE bits 13:7, RETI the whole word, RETLIT bits 13:10).
`define LMR_OPC_IOR   6'h04
`define LMR_OPC_MOVE  6'h08
`define LMR_OPC_ROTL  6'h0d
`define LMR_OPC_ROTR  6'h0c
`define LMR_OPC_STORE 7'h01
`define LMR_OPC_RETI  14'h0009
`define LMR_OPC_RETLIT 4'hd

`endif

/* lmr_exec.sv */
// Purpose: Executes the OR, move, store, rotate and return instructions.
// Assumes: Software writes one 14-bit instruction word at a time over APB.
// Notes: APB stalls while an instruction is in flight.
`timescale 1ns/1ps
`include "lmr_consts.svh"
module lmr_exec
  import lmr_pkg::*;
(
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rstn,
  // APB slave.
  input  wire logic [7:0]   paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Core state.
  output logic              globalIntEnable
);

  lmr_state_t              state_r;
  lmr_state_t              state_nxt;
  lmr_op_t                 opKind;
  logic [`LMR_IW-1:0]      instr_r;
  logic [`LMR_DW-1:0]      accum_r;
  logic                    carry_r;
  logic                    zero_r;
  logic [`LMR_PCW-1:0]     pc_r;
  logic [`LMR_FAW-1:0]     fileAddr_r;
  logic [`LMR_CYW-1:0]     cycles_r;
  logic [`LMR_DW-1:0]      result;
  logic [`LMR_DW-1:0]      fileVal;
  logic [`LMR_DW-1:0]      memRdataW;
  logic [`LMR_DW-1:0]      literal;
  logic [`LMR_FAW-1:0]     fAddr;
  logic                    dBit;
  logic                    exec;
  logic                    isReturn;
  logic                    usesDest;
  logic                    toFile;
  logic                    toAcc;
  logic                    apbWr;
  logic                    addrHit;
  logic [31:0]             rdMux;
  logic                    memWe;
  logic [`LMR_FAW-1:0]     memWaddr;
  logic [`LMR_DW-1:0]      memWdata;
  logic [`LMR_FAW-1:0]     memRaddr;
  logic                    stackPush;
  logic                    stackPop;
  logic [`LMR_PCW-1:0]     stackTop;
  logic [`LMR_SPW-1:0]     stackPtr;

  // Instruction fields.
  assign fAddr   = instr_r[`LMR_F_MSB:0];
  assign dBit    = instr_r[`LMR_D_BIT];
  assign literal = instr_r[`LMR_K_MSB:0];
  assign fileVal = memRdataW;

  // Decode the held instruction word into an operation kind.
  always_comb
  begin
    if (instr_r == `LMR_OPC_RETI)
      opKind = LMR_OP_RETI;
    else if (instr_r[`LMR_OP_MSB:`LMR_RL_LSB] == `LMR_OPC_RETLIT)
      opKind = LMR_OP_RETLIT;
    else if (instr_r[`LMR_OP_MSB:`LMR_D_BIT] == `LMR_OPC_STORE)
      opKind = LMR_OP_STORE;
    else if (instr_r[`LMR_OP_MSB:`LMR_OP_LSB] == `LMR_OPC_IOR)
      opKind = LMR_OP_IOR;
    else if (instr_r[`LMR_OP_MSB:`LMR_OP_LSB] == `LMR_OPC_MOVE)
      opKind = LMR_OP_MOVE;
    else if (instr_r[`LMR_OP_MSB:`LMR_OP_LSB] == `LMR_OPC_ROTL)
      opKind = LMR_OP_ROTL;
    else if (instr_r[`LMR_OP_MSB:`LMR_OP_LSB] == `LMR_OPC_ROTR)
      opKind = LMR_OP_ROTR;
    else
      opKind = LMR_OP_OTHER;
  end

  // Compute the byte result of the file-operate group.
  always_comb
  begin
    case (opKind)
      LMR_OP_IOR:   result = accum_r | fileVal;
      LMR_OP_MOVE:  result = fileVal;
      LMR_OP_ROTL:  result = {fileVal[`LMR_DW-2:0], carry_r};
      LMR_OP_ROTR:  result = {carry_r, fileVal[`LMR_DW-1:1]};
      LMR_OP_STORE: result = accum_r;
      default:      result = 8'h00;
    endcase
  end

  // Steering of the result to accumulator or file byte.
  assign exec     = (state_r == LMR_EXEC);
  assign isReturn = (opKind == LMR_OP_RETI) || (opKind == LMR_OP_RETLIT);
  assign usesDest = (opKind == LMR_OP_IOR) || (opKind == LMR_OP_MOVE) ||
                    (opKind == LMR_OP_ROTL) || (opKind == LMR_OP_ROTR);
  assign toFile   = exec && ((opKind == LMR_OP_STORE) || (usesDest && dBit));
  assign toAcc    = exec && usesDest && !dBit;

  // APB: a write lands at the edge where the master sees pready high.
  assign apbWr   = psel && penable && pready && pwrite && !pslverr;
  assign addrHit = (paddr == `LMR_OFF_INSTR) || (paddr == `LMR_OFF_ACCUM) ||
                   (paddr == `LMR_OFF_STAT)  || (paddr == `LMR_OFF_PC)    ||
                   (paddr == `LMR_OFF_STACK) || (paddr == `LMR_OFF_FADDR) ||
                   (paddr == `LMR_OFF_FDATA) || (paddr == `LMR_OFF_CYC);

  // Read data selection.
  always_comb
  begin
    rdMux = 32'h0;
    case (paddr)
      `LMR_OFF_INSTR: rdMux[`LMR_IW-1:0]  = instr_r;
      `LMR_OFF_ACCUM: rdMux[`LMR_DW-1:0]  = accum_r;
      `LMR_OFF_STAT:
      begin
        rdMux[`LMR_ST_C]   = carry_r;
        rdMux[`LMR_ST_Z]   = zero_r;
        rdMux[`LMR_ST_GLOBEN] = globalIntEnable;
      end
      `LMR_OFF_PC:    rdMux[`LMR_PCW-1:0] = pc_r;
      `LMR_OFF_STACK: rdMux = {13'h0, stackPtr, 3'h0, stackTop};
      `LMR_OFF_FADDR: rdMux[`LMR_FAW-1:0] = fileAddr_r;
      `LMR_OFF_FDATA: rdMux[`LMR_DW-1:0]  = fileVal;
      `LMR_OFF_CYC:   rdMux[`LMR_CYW-1:0] = cycles_r;
      default:        rdMux = 32'h0;
    endcase
  end

  // APB answer: one wait cycle, and none at all while an instruction runs.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready <= 1'b0;
      if (psel && penable && !pready && (state_r == LMR_IDLE))
      begin
        pready  <= 1'b1;
        pslverr <= !addrHit;
        prdata  <= pwrite ? 32'h0 : rdMux;
      end
    end
  end

  // Sequencer: read the file byte, execute, and hold a second cycle for returns.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      LMR_IDLE:  if (apbWr && (paddr == `LMR_OFF_INSTR)) state_nxt = LMR_READ;
      LMR_READ:  state_nxt = LMR_EXEC;
      LMR_EXEC:  state_nxt = isReturn ? LMR_EXEC2 : LMR_IDLE;
      LMR_EXEC2: state_nxt = LMR_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_r <= LMR_IDLE;
    else
      state_r <= state_nxt;
  end

  // Instruction word latch.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      instr_r <= 14'h0000;
    else if (apbWr && (paddr == `LMR_OFF_INSTR))
      instr_r <= pwdata[`LMR_IW-1:0];
  end

  // Accumulator: software write, file-operate result, or returned literal.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      accum_r <= 8'h00;
    else if (exec && (opKind == LMR_OP_RETLIT))
      accum_r <= literal;
    else if (toAcc)
      accum_r <= result;
    else if (apbWr && (paddr == `LMR_OFF_ACCUM))
      accum_r <= pwdata[`LMR_DW-1:0];
  end

  // Zero flag: only the OR and move instructions touch it.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      zero_r <= 1'b0;
    else if (exec && ((opKind == LMR_OP_IOR) || (opKind == LMR_OP_MOVE)))
      zero_r <= (result == 8'h00);
    else if (apbWr && (paddr == `LMR_OFF_STAT))
      zero_r <= pwdata[`LMR_ST_Z];
  end

  // Carry flag: only rotates touch it; the bit shifted out is the new carry.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      carry_r <= 1'b0;
    else if (exec && (opKind == LMR_OP_ROTL))
      carry_r <= fileVal[`LMR_DW-1];
    else if (exec && (opKind == LMR_OP_ROTR))
      carry_r <= fileVal[0];
    else if (apbWr && (paddr == `LMR_OFF_STAT))
      carry_r <= pwdata[`LMR_ST_C];
  end

  // Global interrupt enable: set by the interrupt return.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      globalIntEnable <= 1'b0;
    else if (exec && (opKind == LMR_OP_RETI))
      globalIntEnable <= 1'b1;
    else if (apbWr && (paddr == `LMR_OFF_STAT))
      globalIntEnable <= pwdata[`LMR_ST_GLOBEN];
  end

  // Program counter: returns load the stack top, others step by one.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pc_r <= 13'h0000;
    else if (exec && isReturn)
      pc_r <= stackTop;
    else if (exec)
      pc_r <= pc_r + 13'h0001;
    else if (apbWr && (paddr == `LMR_OFF_PC))
      pc_r <= pwdata[`LMR_PCW-1:0];
  end

  // Software file address pointer.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fileAddr_r <= 7'h00;
    else if (apbWr && (paddr == `LMR_OFF_FADDR))
      fileAddr_r <= pwdata[`LMR_FAW-1:0];
  end

  // Instruction-cycle counter; each return, literal or interrupt, adds two.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cycles_r <= 16'h0000;
    else if (apbWr && (paddr == `LMR_OFF_CYC))
      cycles_r <= 16'h0000;
    else if (exec || (state_r == LMR_EXEC2))
      cycles_r <= cycles_r + 16'h0001;
  end

  // File memory ports; execution owns them outside idle.
  assign memWe    = toFile || (apbWr && (paddr == `LMR_OFF_FDATA));
  assign memWaddr = toFile ? fAddr : fileAddr_r;
  assign memWdata = toFile ? result : pwdata[`LMR_DW-1:0];
  assign memRaddr = (state_r == LMR_IDLE) ? fileAddr_r : fAddr;

  lmr_file_mem lmr_file_mem_i
  (
    .clock  (clock),
    .wrEn   (memWe),
    .wrAddr (memWaddr),
    .wrData (memWdata),
    .rdAddr (memRaddr),
    .rdData (memRdataW)
  );

  // Return stack: software pushes, returns pop.
  assign stackPush = apbWr && (paddr == `LMR_OFF_STACK);
  assign stackPop  = exec && isReturn;

  lmr_ret_stack lmr_ret_stack_i
  (
    .clock    (clock),
    .rstn     (rstn),
    .push     (stackPush),
    .pushData (pwdata[`LMR_PCW-1:0]),
    .pop      (stackPop),
    .stackTop (stackTop),
    .stackPtr (stackPtr)
  );

endmodule

/* lmr_exec_checker.sv */
// Purpose: Port-level assertions for the execution block.
// Assumes: APB master holds each request until pready.
// Notes: Watches only the top module's ports.
`timescale 1ns/1ps
module lmr_exec_checker
(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rstn,
  // APB slave.
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core state.
  input wire logic        globalIntEnable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Accepted transfers, instruction writes and return opcodes.
  wire hs    = psel & penable & pready;
  wire wrI   = hs & pwrite & (paddr == 8'h00);
  wire rdS   = hs & !pwrite & (paddr == 8'h08);
  wire reti  = pwdata[13:0] == 14'h0009;
  wire isRet = reti | (pwdata[13:10] == 4'hd);

  reti_sets_enable_a: assert property (wrI && reti |-> ##[1:4] globalIntEnable)
    else $error("interrupt return left global enable low");
  enable_kept_a: assert property (globalIntEnable && !(hs && pwrite && paddr == 8'h08)
    |=> globalIntEnable)
    else $error("global enable dropped without a status write");
  enable_status_a: assert property (rdS |-> prdata[7] == globalIntEnable)
    else $error("status bit 7 differs from global enable");
  ret_stall_a: assert property (wrI && isRet |=> !pready [*3])
    else $error("return finished in fewer than two cycles");
  op_stall_a: assert property (wrI && !isRet |=> !pready [*2])
    else $error("bus answered while an instruction ran");
  answer_bound_a: assert property (psel && penable && !pready |-> ##[1:4] pready)
    else $error("bus answer took too long");
  accum_width_a: assert property (hs && !pwrite && paddr == 8'h04 |-> prdata[31:8] == 0)
    else $error("accumulator read wider than 8 bits");
  status_bits_a: assert property (rdS |-> prdata[31:8] == 0 && prdata[6:3] == 0
    && !prdata[1])
    else $error("status read shows unused bits");
endmodule

/* lmr_file_mem.sv */
// Purpose: File register space, one write port and one registered read port.
// Assumes: Single clock; contents are not reset.
// Notes: Read data appear one clock after the address.
`timescale 1ns/1ps
`include "lmr_consts.svh"
module lmr_file_mem
  import lmr_pkg::*;
(
  // Clock.
  input  wire logic                 clock,
  // Write port.
  input  wire logic                 wrEn,
  input  wire logic [`LMR_FAW-1:0]  wrAddr,
  input  wire logic [`LMR_DW-1:0]   wrData,
  // Read port.
  input  wire logic [`LMR_FAW-1:0]  rdAddr,
  output logic      [`LMR_DW-1:0]   rdData
);

  logic [`LMR_DW-1:0] mem [0:(1<<`LMR_FAW)-1];

  // Store a byte on a write strobe.
  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read; a same-cycle write shows one clock later.
  always_ff @(posedge clock)
  begin
    rdData <= mem[rdAddr];
  end

endmodule

/* lmr_pkg.sv */
// Purpose: Types shared by the execution block.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot.
package lmr_pkg;

  // Execution sequencer states.
  typedef enum logic [3:0]
  {
    LMR_IDLE  = 4'b0001,
    LMR_READ  = 4'b0010,
    LMR_EXEC  = 4'b0100,
    LMR_EXEC2 = 4'b1000
  } lmr_state_t;

  // Decoded operation kinds.
  typedef enum logic [2:0]
  {
    LMR_OP_OTHER  = 3'h0,
    LMR_OP_IOR    = 3'h1,
    LMR_OP_STORE  = 3'h2,
    LMR_OP_MOVE   = 3'h3,
    LMR_OP_RETI   = 3'h4,
    LMR_OP_ROTL   = 3'h5,
    LMR_OP_ROTR   = 3'h6,
    LMR_OP_RETLIT = 3'h7
  } lmr_op_t;

endpackage

/* lmr_ret_stack.sv */
// Purpose: Eight-level hardware return stack.
// Assumes: Push and pop never coincide.
// Notes: The pointer wraps; overflow overwrites the oldest entry.
`timescale 1ns/1ps
`include "lmr_consts.svh"
module lmr_ret_stack
  import lmr_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // Push and pop strobes.
  input  wire logic                 push,
  input  wire logic [`LMR_PCW-1:0]  pushData,
  input  wire logic                 pop,
  // Top of stack and pointer.
  output logic      [`LMR_PCW-1:0]  stackTop,
  output logic      [`LMR_SPW-1:0]  stackPtr
);

  logic [`LMR_PCW-1:0] entry [0:(1<<`LMR_SPW)-1];
  logic [`LMR_SPW-1:0] topIdx;

  assign topIdx   = stackPtr - 3'h1;
  assign stackTop = entry[topIdx];

  // Write the entry at the pointer on a push.
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      entry[stackPtr] <= pushData;
    end
  end

  // Move the pointer up on push and down on pop.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stackPtr <= 3'h0;
    end
    else if (push)
    begin
      stackPtr <= stackPtr + 3'h1;
    end
    else if (pop)
    begin
      stackPtr <= stackPtr - 3'h1;
    end
  end

endmodule

/* test_logic_move_rotate_return_exec.sv */
// Purpose: Self-checking bench for the execution block.
// Assumes: Register map and opcodes of the execution block.
// Notes: Expected values are computed here from the instruction rules.
`timescale 1ns/1ps
module test_logic_move_rotate_return_exec import lmr_pkg::*;;
  // Bench signals.
  logic        clock, rstn, psel, penable, pwrite, pready, pslverr, globEn, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          nErrors, checksDone;
  logic [5:0]  ops [5] = '{6'h04, 6'h08, 6'h0d, 6'h0c, 6'h00};

  lmr_exec lmr_exec_i (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .globalIntEnable(globEn));

  // Clock at 4 ns period.
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e)
    begin
      nErrors++;
      $display("ERROR at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      nErrors++;
      $display("ERROR at %0t: no bus answer", $time);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask

  // Loads operands, runs one file instruction and checks the outcome.
  task automatic run(input logic [5:0] op, input logic d, input logic [7:0] f,
                     input logic [7:0] a, input logic [7:0] st);
    logic [7:0]  r, se;
    logic [31:0] pc;
    se = st;
    r = (op == 6'h04) ? (a | f) : (op == 6'h08) ? f : (op == 6'h0d) ? {f[6:0], st[0]}
      : (op == 6'h0c) ? {st[0], f[7:1]} : a;
    if (op == 6'h04 || op == 6'h08)
      se[2] = (r == 8'h00);
    if (op == 6'h0d)
      se[0] = f[7];
    if (op == 6'h0c)
      se[0] = f[0];
    wr(8'h14, 32'h5);
    wr(8'h18, {24'h0, f});
    wr(8'h04, {24'h0, a});
    wr(8'h08, {24'h0, st});
    apb(8'h0c, 1'b0, 32'h0);
    pc = rd;
    wr(8'h00, {18'h0, op, d, 7'h05});
    rdc(8'h04, {24'h0, d ? a : r});
    rdc(8'h18, {24'h0, d ? r : f});
    rdc(8'h08, {24'h0, se});
    rdc(8'h0c, pc + 1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrapUp;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rdc(8'h08, 32'h0);
    chk({31'h0, globEn}, 32'h0);
    $display("reset test done");
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 5; i++)
        for (int d = 0; d < 2; d++)
          if (i < 4 || d == 1)
            run(ops[i], d[0], s ? 8'h00 : 8'h80, s ? 8'h00 : 8'h3c, s ? 8'h01 : 8'h05);
    $display("file operation test done");
    wr(8'h08, 32'h05);
    wr(8'h10, 32'h0abc);
    rdc(8'h10, 32'h10abc);
    wr(8'h00, 32'h0009);
    rdc(8'h0c, 32'h0abc);
    rdc(8'h08, 32'h85);
    chk({31'h0, globEn}, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h10, 32'h1234);
      wr(8'h1c, 32'h0);
      wr(8'h00, {18'h0, 6'h34, k ? 8'hff : 8'h00});
      rdc(8'h04, k ? 32'hff : 32'h0);
      rdc(8'h0c, 32'h1234);
      rdc(8'h1c, 32'h2);
      rdc(8'h08, 32'h85);
    end
    wr(8'h00, 32'h0);
    rdc(8'h0c, 32'h1235);
    rdc(8'h04, 32'hff);
    rdc(8'h1c, 32'h3);
    $display("return test done");
    apb(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(8'h24, 32'h1);
    chk({31'h0, err}, 32'h1);
    $display("unmapped test done");
    wrapUp;
  end

  // Cuts a hang short.
  initial
  begin
    #200000;
    nErrors++;
    wrapUp;
  end
endmodule

bind lmr_exec lmr_exec_checker lmr_exec_checker_i (.clock(clock), .rstn(rstn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .globalIntEnable(globalIntEnable));
